/* File: design/rf_integrity_pkg.sv */
package rf_integrity_pkg;
   // register offsets on the host byte port
   localparam logic [5:0] ADDR_RX_GUARD    = 6'h21;
   localparam logic [5:0] ADDR_CFG         = 6'h22;
   localparam logic [5:0] ADDR_SEED_LOW    = 6'h23;
   localparam logic [5:0] ADDR_SEED_HIGH   = 6'h24;
   localparam logic [5:0] ADDR_FIXED       = 6'h25;
   // reset values
   localparam logic [7:0] RST_RX_GUARD     = 8'h06;
   localparam logic [7:0] RST_CFG          = 8'h03;
   localparam logic [7:0] RST_SEED_LOW     = 8'h63;
   localparam logic [7:0] RST_SEED_HIGH    = 8'h63;
   localparam logic [7:0] RST_FIXED        = 8'h00;
   // integrity_check_config field positions
   localparam int         BIT_PARITY_EN    = 0;
   localparam int         BIT_ODD_PARITY   = 1;
   localparam int         BIT_TX_APPEND    = 2;
   localparam int         BIT_RX_CHECK     = 3;
   localparam int         BIT_SHORT_WIDTH  = 4;
   localparam int         BIT_ALT_STANDARD = 5;
   // reflected polynomials, lsb first
   localparam logic [15:0] CRC16_POLY      = 16'h8408;
   localparam logic [7:0]  CRC_SHORT_WIDTH_POLY       = 8'h8c;
   // transmit buffer shape
   localparam int         FIFO_WIDTH       = 8;
   localparam int         FIFO_DEPTH       = 8;

   // sequencer states, gray along idle-send-parity-guard-receive
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SEND   = 3'b001,
      ST_PARITY = 3'b011,
      ST_GUARD  = 3'b010,
      ST_RECV   = 3'b110,
      ST_CALC   = 3'b100
   } seq_state_t;

   // fold one byte into the checksum, lsb first
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data,
                                            input logic short_w);
      logic [15:0] c;
      logic        fb;
      c  = crc;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         fb = c[0] ^ data[i];
         if (short_w) begin
            c = {8'h00, (c[7:0] >> 1) ^ (fb ? CRC_SHORT_WIDTH_POLY : 8'h00)};
         end else begin
            c = (c >> 1) ^ (fb ? CRC16_POLY : 16'h0000);
         end
      end
      return c;
   endfunction : crc_byte
endpackage : rf_integrity_pkg

/* File: design/rf_channel_integrity_config.sv */
// Overview of operation
// - receiver waits guard delay bit clocks after transmit
// - receive input ignored during guard interval
// - bit 5 selects alternate crc, else type A
// - bit 4 selects 8-bit crc, else 16-bit
// - rx check treats trailing bytes as crc, withholds
// - crc mismatch sets error flag; disabled expects none
// - tx append computes and appends crc bytes
// - bit 1 selects odd parity, else even
// - parity bit after each byte when enabled
// - seed bytes preset crc at each start
// - 8-bit width uses only low seed byte

// synchronous buffer with registered flags
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];        // storage words
   logic [PW-1:0]    wr_ptr, next_wr_ptr; // write position
   logic [PW-1:0]    rd_ptr, next_rd_ptr; // read position
   logic [PW:0]      count, next_count;   // words held
   logic             push, pop;

   // pointer and flag arithmetic
   always_comb begin
      push        = in_valid & in_ready;
      pop         = out_valid & out_ready;
      next_wr_ptr = push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      next_rd_ptr = pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   // register pointers, flags and storage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= next_count != (PW+1)'(DEPTH);
         out_valid <= next_count != '0;
         if (push) begin
            mem[wr_ptr] <= in_data;
         end
      end
   end

   assign out_data = mem[rd_ptr];       // read word at head
endmodule : byte_fifo

module rf_channel_integrity_config
   import rf_integrity_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // host byte register port
   input  wire logic [5:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // transmit bytes and commands
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic       tx_start,
   input  wire logic       compute_checksum_command,
   // bit link toward the card
   input  wire logic       bit_tick,
   output logic            tx_bit,
   output logic            tx_bit_valid,
   input  wire logic       rx_in,
   input  wire logic       rx_in_valid,
   input  wire logic       rx_frame_end,
   // received bytes and status
   output logic      [7:0] rx_data,
   output logic            rx_valid,
   output logic            check_error_flag,
   output logic            parity_error,
   output logic     [15:0] crc_value,
   output logic            rx_enabled,
   output logic            busy
);
   // registers and their next values
   logic [7:0]  rx_guard_delay, next_rx_guard_delay;   // guard length in bit clocks
   logic [7:0]  integrity_check_config, next_cfg;      // mode bits
   logic [7:0]  check_seed_low, next_seed_low;         // preset low byte
   logic [7:0]  check_seed_high, next_seed_high;       // preset high byte
   logic [7:0]  reserved_fixed_byte, next_fixed;       // kept, not used
   logic [7:0]  next_rdata;
   // sequencer state
   seq_state_t  state, next_state;
   logic [7:0]  sh, next_sh;                 // outgoing byte, indexed not shifted
   logic [2:0]  bit_cnt, next_bit_cnt;       // bits sent of byte
   logic [15:0] crc, next_crc;               // running checksum
   logic [15:0] crc_word, next_crc_word;     // pending crc high byte
   logic        crc_left, next_crc_left;     // one crc byte pending
   logic        crc_done, next_crc_done;     // crc already queued
   logic [7:0]  guard_cnt, next_guard_cnt;   // guard countdown
   logic [7:0]  rx_sh, next_rx_sh;           // incoming byte shifter
   logic [3:0]  rx_cnt, next_rx_cnt;         // bits received of byte
   logic [15:0] pipe, next_pipe;             // withheld trailing bytes
   logic [1:0]  pc, next_pc;                 // bytes held in pipe
   logic        next_tx_bit, next_tx_bit_valid, next_rx_valid;
   logic [7:0]  next_rx_data;
   logic        next_err, next_par_err, next_rx_enabled;
   logic [15:0] next_crc_value;
   // combinational helpers
   logic        short_w, alt_std, odd_par, par_en;
   logic [1:0]  need;
   logic [15:0] seed, mask, c, fin;
   logic        load_next, pop, got;
   logic [7:0]  nb, oldest;
   logic [7:0]  fifo_data;
   logic        fifo_valid;

   // transmit bytes wait here; drained one byte per sent byte when sending (once per clock in checksum mode), so it fills
   byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pop)
   );

   // register writes and read data
   always_comb begin
      next_rx_guard_delay = rx_guard_delay;
      next_cfg            = integrity_check_config;
      next_seed_low       = check_seed_low;
      next_seed_high      = check_seed_high;
      next_fixed          = reserved_fixed_byte;
      next_rdata          = reg_rdata;
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_RX_GUARD:  next_rx_guard_delay = reg_wdata;
            ADDR_CFG:       next_cfg            = reg_wdata;
            ADDR_SEED_LOW:  next_seed_low       = reg_wdata;
            ADDR_SEED_HIGH: next_seed_high      = reg_wdata;
            ADDR_FIXED:     next_fixed          = reg_wdata;
            default:        ;                   // unmapped write dropped
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_RX_GUARD:  next_rdata = rx_guard_delay;
            ADDR_CFG:       next_rdata = integrity_check_config;
            ADDR_SEED_LOW:  next_rdata = check_seed_low;
            ADDR_SEED_HIGH: next_rdata = check_seed_high;
            ADDR_FIXED:     next_rdata = reserved_fixed_byte;
            default:        next_rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end

   // register file flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_guard_delay         <= RST_RX_GUARD;
         integrity_check_config <= RST_CFG;
         check_seed_low         <= RST_SEED_LOW;
         check_seed_high        <= RST_SEED_HIGH;
         reserved_fixed_byte    <= RST_FIXED;
         reg_rdata              <= 8'h00;
      end else begin
         rx_guard_delay         <= next_rx_guard_delay;
         integrity_check_config <= next_cfg;
         check_seed_low         <= next_seed_low;
         check_seed_high        <= next_seed_high;
         reserved_fixed_byte    <= next_fixed;
         reg_rdata              <= next_rdata;
      end
   end

   // mode decode shared by both directions
   always_comb begin
      short_w = integrity_check_config[BIT_SHORT_WIDTH];
      alt_std = integrity_check_config[BIT_ALT_STANDARD];
      odd_par = integrity_check_config[BIT_ODD_PARITY];
      par_en  = integrity_check_config[BIT_PARITY_EN];
      need    = integrity_check_config[BIT_RX_CHECK] ? (short_w ? 2'd1 : 2'd2) : 2'd0;
      seed    = short_w ? {8'h00, check_seed_low}
                        : {check_seed_high, check_seed_low};
      mask    = short_w ? 16'h00ff : 16'hffff;
      fin     = (alt_std ? ~crc : crc) & mask;
   end

   // sequencer next values
   always_comb begin
      next_state        = state;
      next_sh           = sh;
      next_bit_cnt      = bit_cnt;
      next_crc          = crc;
      next_crc_word     = crc_word;
      next_crc_left     = crc_left;
      next_crc_done     = crc_done;
      next_guard_cnt    = guard_cnt;
      next_rx_sh        = rx_sh;
      next_rx_cnt       = rx_cnt;
      next_pipe         = pipe;
      next_pc           = pc;
      next_tx_bit       = tx_bit;
      next_tx_bit_valid = 1'b0;
      next_rx_valid     = 1'b0;
      next_rx_data      = rx_data;
      next_err          = check_error_flag;
      next_par_err      = parity_error;
      next_rx_enabled   = rx_enabled;
      next_crc_value    = crc_value;
      c                 = crc;
      load_next         = 1'b0;
      pop               = 1'b0;
      got               = 1'b0;
      nb                = 8'h00;
      oldest            = (pc == 2'd2) ? pipe[7:0] : pipe[15:8];
      unique case (state)
         ST_IDLE: begin
            if (tx_start) begin
               c             = seed;
               next_crc_left = 1'b0;
               next_crc_done = 1'b0;
               load_next     = 1'b1;
            end else if (compute_checksum_command) begin
               next_crc   = seed;
               next_state = ST_CALC;
            end
         end
         ST_CALC: begin
            if (fifo_valid) begin
               pop      = 1'b1;
               next_crc = crc_byte(crc, fifo_data, short_w);
            end else begin
               next_crc_value = fin;
               next_state     = ST_IDLE;
            end
         end
         ST_SEND: begin
            if (bit_tick) begin
               // index the bit, keep the byte whole for the parity bit
               next_tx_bit       = sh[bit_cnt];
               next_tx_bit_valid = 1'b1;
               next_bit_cnt      = bit_cnt + 3'd1;
               if (bit_cnt == 3'd7) begin
                  if (par_en) begin
                     next_state = ST_PARITY;
                  end else begin
                     load_next = 1'b1;
                  end
               end
            end
         end
         ST_PARITY: begin
            if (bit_tick) begin
               next_tx_bit       = (^sh) ^ odd_par;
               next_tx_bit_valid = 1'b1;
               load_next         = 1'b1;
            end
         end
         ST_GUARD: begin
            // receive input is not looked at here
            if (guard_cnt == 8'h00) begin
               next_state      = ST_RECV;
               next_rx_enabled = 1'b1;
               next_crc        = seed;
               next_pc         = 2'd0;
               next_pipe       = 16'h0000;                            // no stale bytes
               next_rx_cnt     = 4'd0;
               next_err        = 1'b0;
               next_par_err    = 1'b0;
            end else if (bit_tick) begin
               next_guard_cnt = guard_cnt - 8'd1;
            end
         end
         ST_RECV: begin
            if (rx_frame_end) begin
               next_state      = ST_IDLE;
               next_rx_enabled = 1'b0;
               next_crc_value  = fin;
               if (need != 2'd0) begin
                  if (pc != need || pipe != ((need == 2'd2) ? fin : {fin[7:0], 8'h00})) begin
                     next_err = 1'b1;
                  end
               end
            end else if (rx_in_valid) begin
               if (rx_cnt == 4'd8) begin
                  got         = 1'b1;
                  nb          = rx_sh;
                  next_rx_cnt = 4'd0;
                  if (rx_in != ((^rx_sh) ^ odd_par)) begin
                     next_par_err = 1'b1;
                  end
               end else begin
                  next_rx_sh  = {rx_in, rx_sh[7:1]};
                  next_rx_cnt = rx_cnt + 4'd1;
                  if (rx_cnt == 4'd7 && !par_en) begin
                     got         = 1'b1;
                     nb          = {rx_in, rx_sh[7:1]};
                     next_rx_cnt = 4'd0;
                  end
               end
            end
            if (got) begin
               if (need == 2'd0) begin
                  next_rx_data  = nb;
                  next_rx_valid = 1'b1;
                  next_crc      = crc_byte(crc, nb, short_w);
               end else begin
                  next_pipe = {nb, pipe[15:8]};
                  if (pc == need) begin
                     next_rx_data  = oldest;
                     next_rx_valid = 1'b1;
                     next_crc      = crc_byte(crc, oldest, short_w);
                     if (need == 2'd1) begin
                        next_pipe = {nb, 8'h00};
                     end
                  end else begin
                     next_pc = pc + 2'd1;
                  end
               end
            end
         end
         default: next_state = ST_IDLE;                               // illegal code
      endcase
      // fetch the next outgoing byte: data, then crc, then guard
      if (load_next) begin
         next_bit_cnt = 3'd0;
         next_state   = ST_SEND;
         if (fifo_valid) begin
            pop      = 1'b1;
            next_sh  = fifo_data;
            next_crc = crc_byte(c, fifo_data, short_w);
         end else if (integrity_check_config[BIT_TX_APPEND] && !crc_done) begin
            c             = (alt_std ? ~c : c) & mask;
            next_sh       = c[7:0];
            next_crc_word = {8'h00, c[15:8]};
            next_crc_left = !short_w;
            next_crc_done = 1'b1;
         end else if (crc_left) begin
            next_sh       = crc_word[7:0];
            next_crc_left = 1'b0;
         end else begin
            next_guard_cnt = rx_guard_delay;
            next_state     = ST_GUARD;
         end
      end
   end

   // sequencer flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state            <= ST_IDLE;
         sh               <= 8'h00;
         bit_cnt          <= 3'd0;
         crc              <= 16'h0000;
         crc_word         <= 16'h0000;
         crc_left         <= 1'b0;
         crc_done         <= 1'b0;
         guard_cnt        <= 8'h00;
         rx_sh            <= 8'h00;
         rx_cnt           <= 4'd0;
         pipe             <= 16'h0000;
         pc               <= 2'd0;
         tx_bit           <= 1'b0;
         tx_bit_valid     <= 1'b0;
         rx_data          <= 8'h00;
         rx_valid         <= 1'b0;
         check_error_flag <= 1'b0;
         parity_error     <= 1'b0;
         crc_value        <= 16'h0000;
         rx_enabled       <= 1'b0;
         busy             <= 1'b0;
      end else begin
         state            <= next_state;
         sh               <= next_sh;
         bit_cnt          <= next_bit_cnt;
         crc              <= next_crc;
         crc_word         <= next_crc_word;
         crc_left         <= next_crc_left;
         crc_done         <= next_crc_done;
         guard_cnt        <= next_guard_cnt;
         rx_sh            <= next_rx_sh;
         rx_cnt           <= next_rx_cnt;
         pipe             <= next_pipe;
         pc               <= next_pc;
         tx_bit           <= next_tx_bit;
         tx_bit_valid     <= next_tx_bit_valid;
         rx_data          <= next_rx_data;
         rx_valid         <= next_rx_valid;
         check_error_flag <= next_err;
         parity_error     <= next_par_err;
         crc_value        <= next_crc_value;
         rx_enabled       <= next_rx_enabled;
         busy             <= next_state != ST_IDLE;
      end
   end
endmodule : rf_channel_integrity_config

/* File: tb/rf_integrity_monitor.sv */
module rf_integrity_monitor (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       srst,
   // host writes
   input wire logic [5:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   // commands
   input wire logic       tx_start,
   input wire logic       compute_checksum_command,
   // bit link and status
   input wire logic       bit_tick,
   input wire logic       tx_bit_valid,
   input wire logic       rx_frame_end,
   input wire logic       rx_valid,
   input wire logic       rx_enabled,
   input wire logic       busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  guard;       // shadow of the guard delay
   logic [7:0]  next_guard;  // next shadow value
   logic [15:0] ticks;       // bit ticks since the last sent bit
   logic [15:0] next_ticks;  // next tick count
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // follow guard writes, count ticks after each sent bit
   always_comb begin
      next_guard = (reg_wr && reg_addr == 6'h21) ? reg_wdata : guard;
      next_ticks = tx_bit_valid ? 16'h0000 : ticks + 16'(bit_tick);
   end
   // register the helper state
   always_ff @(posedge sys_clk) begin
      guard <= srst ? 8'h06 : next_guard;
      ticks <= srst ? 16'h0000 : next_ticks;
   end
   a_guard_length: assert property ($rose(rx_enabled) |-> ticks == 16'(guard))
      else $error("receiver opened after a wrong tick count");
   a_send_deaf: assert property (tx_bit_valid |-> !rx_enabled)
      else $error("receiver open while sending");
   a_idle_deaf: assert property (!busy |-> !rx_enabled)
      else $error("receiver open while idle");
   a_bit_on_tick: assert property (tx_bit_valid |-> $past(bit_tick))
      else $error("bit sent without a bit tick");
   a_byte_in_frame: assert property (rx_valid |-> $past(rx_enabled))
      else $error("byte decoded outside reception");
   a_frame_close: assert property (rx_enabled && rx_frame_end |=> !rx_enabled)
      else $error("receiver stayed open after frame end");
   a_start_taken: assert property (tx_start && !busy |=> busy)
      else $error("transmit start not taken");
   a_calc_taken: assert property (compute_checksum_command && !busy |=> busy)
      else $error("checksum command not taken");
endmodule : rf_integrity_monitor
bind rf_channel_integrity_config rf_integrity_monitor mon (.sys_clk, .srst, .reg_addr,
   .reg_wr, .reg_wdata, .tx_start, .compute_checksum_command, .bit_tick, .tx_bit_valid,
   .rx_frame_end, .rx_valid, .rx_enabled, .busy);

/* File: tb/card_model.sv */
module card_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // reader to card
   output logic      bit_tick,
   input  wire logic tx_bit,
   input  wire logic tx_bit_valid,
   // card to reader
   output logic      rx_in,
   output logic      rx_in_valid,
   output logic      rx_frame_end,
   input  wire logic rx_enabled
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div = 2'h0;  // bit period of four clocks
   logic       fin = 1'b0;  // frame end owed
   bit         q_bits[$];   // bits heard from the reader
   bit         out_q[$];    // bits queued for the reader
   initial {bit_tick, rx_in, rx_in_valid, rx_frame_end} = 4'h0;
   // bit tick divider and capture of sent bits
   always @(posedge sys_clk) begin
      div      <= srst ? 2'h0 : div + 2'h1;
      bit_tick <= !srst && div == 2'h3;
      if (tx_bit_valid) q_bits.push_back(tx_bit);
   end
   // answer on ticks, chatter while the reader is deaf
   always @(posedge sys_clk) begin
      rx_in_valid  <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_in        <= ~rx_in;
      if (div == 2'h3 && out_q.size() > 0) begin
         rx_in_valid <= 1'b1;
         rx_in       <= out_q.pop_front();
         fin         <= 1'b1;
      end else if (div == 2'h3 && fin) begin
         rx_frame_end <= 1'b1;
         fin          <= 1'b0;
      end else if (div == 2'h3) begin
         rx_in_valid <= !rx_enabled;
      end
   end
endmodule : card_model

/* File: tb/tb_rf_channel_integrity_config.sv */
module tb_rf_channel_integrity_config;
   import rf_integrity_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, srst, reg_wr, reg_rd, tx_valid, tx_ready, tx_start, calc;
   logic [5:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, tx_data, rx_data, lfsr;
   logic        bit_tick, tx_bit, tx_bit_valid, rx_in, rx_in_valid, rx_frame_end;
   logic        rx_valid, check_error_flag, parity_error, rx_enabled, busy;
   logic [15:0] crc_value;
   int          errors, checked;
   logic [7:0]  rxq[$];  // bytes handed up
   logic [7:0]  rst_tab[6] = '{8'h06, 8'h03, 8'h63, 8'h63, 8'h00, 8'h00};
   // row 0 is type A: standard crc, odd parity bits 7:6 zero
   logic [7:0]  cfg_tab[4] = '{8'h0f, 8'h1d, 8'h2c, 8'h03};
   always #50 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
   rf_channel_integrity_config DUT (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .tx_data, .tx_valid, .tx_ready, .tx_start, .compute_checksum_command(calc),
      .bit_tick, .tx_bit, .tx_bit_valid, .rx_in, .rx_in_valid, .rx_frame_end, .rx_data,
      .rx_valid, .check_error_flag, .parity_error, .crc_value, .rx_enabled, .busy);
   card_model card (.sys_clk, .srst, .bit_tick, .tx_bit, .tx_bit_valid, .rx_in, .rx_in_valid,
      .rx_frame_end, .rx_enabled);
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction : rnd
   // reference checksum, lsb first
   function automatic logic [15:0] crc_ref(input logic [7:0] q[$], input logic [7:0] cfg,
                                           input logic [15:0] seed);
      logic [15:0] c;
      logic [15:0] p;
      c = cfg[4] ? {8'h00, seed[7:0]} : seed;
      p = cfg[4] ? {8'h00, CRC_SHORT_WIDTH_POLY} : CRC16_POLY;
      foreach (q[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? p : 16'h0);
      return cfg[5] ? ~c : c;
   endfunction : crc_ref
   // one byte on the wire, lsb first, then parity
   function automatic void add_byte(ref bit q[$], input logic [7:0] b, input logic [7:0] cfg);
      for (int k = 0; k < 8; k++) q.push_back(b[k]);
      if (cfg[0]) q.push_back(^b ^ cfg[1]);
   endfunction : add_byte
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic must(input logic ok);
      chk(16'(ok), 16'h0001);
      if (ok !== 1'b1) end_sim();
   endtask : must
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      chk(16'(reg_rdata), 16'(e));
   endtask : rd
   // load eight random bytes into the transmit buffer
   task automatic fill(ref logic [7:0] q[$]);
      q.delete();
      @(posedge sys_clk);
      for (int k = 0; k < 8; k++) begin
         q.push_back(rnd());
         tx_data  <= q[k];
         tx_valid <= 1'b1;
         @(posedge sys_clk);
      end
      tx_valid <= 1'b0;
   endtask : fill
   initial begin
      logic [7:0]  data[$];
      logic [15:0] crc, seed;
      bit          exp[$];
      int          ticks;
      {sys_clk, reg_wr, reg_rd, tx_valid, tx_start, calc, reg_addr} = '0;
      {reg_wdata, tx_data} = '0;
      srst = 1'b1;
      lfsr = 8'h14;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      wr(6'h26, 8'h5a); // unmapped write is dropped, fixed byte never written
      for (int k = 0; k < 6; k++) rd(6'(33 + k), rst_tab[k]);
      for (int i = 0; i < 4; i++) begin
         seed = {rnd(), rnd()};
         wr(6'h21, 8'(2 * i));
         wr(6'h22, cfg_tab[i]);
         wr(6'h23, seed[7:0]);
         wr(6'h24, seed[15:8]);
         rd(6'h22, cfg_tab[i]);
         fill(data);
         @(negedge sys_clk);
         chk(16'(tx_ready), 16'h0000); // buffer full after eight
         @(posedge sys_clk);
         tx_start <= 1'b1;
         card.q_bits.delete();
         @(posedge sys_clk);
         tx_start <= 1'b0;
         exp.delete();
         crc = crc_ref(data, cfg_tab[i], seed);
         foreach (data[k]) add_byte(exp, data[k], cfg_tab[i]);
         if (cfg_tab[i][2]) add_byte(exp, crc[7:0], cfg_tab[i]);
         if (cfg_tab[i][2] && !cfg_tab[i][4]) add_byte(exp, crc[15:8], cfg_tab[i]);
         ticks = 0;
         for (int t = 0; t < 3000 && rx_enabled !== 1'b1; t++) begin
            @(negedge sys_clk);
            ticks = tx_bit_valid ? 0 : ticks + int'(bit_tick);
         end
         must(rx_enabled);
         chk(16'(ticks), 16'(2 * i));
         chk(16'(card.q_bits.size()), 16'(exp.size()));
         foreach (exp[k]) chk(16'(card.q_bits[k]), 16'(exp[k]));
         rxq.delete();
         data.delete();
         repeat (3) data.push_back(rnd());
         foreach (data[k]) add_byte(card.out_q, data[k], cfg_tab[i]);
         crc = crc_ref(data, cfg_tab[i], seed) ^ 16'(i % 2); // odd rows corrupt it
         if (cfg_tab[i][3]) add_byte(card.out_q, crc[7:0], cfg_tab[i]);
         if (cfg_tab[i][3] && !cfg_tab[i][4]) add_byte(card.out_q, crc[15:8], cfg_tab[i]);
         for (int t = 0; t < 3000 && rx_enabled === 1'b1; t++) @(negedge sys_clk);
         must(!rx_enabled);
         repeat (2) @(negedge sys_clk);
         chk(16'(check_error_flag), 16'(cfg_tab[i][3] & i[0]));
         chk(crc_value, crc_ref(data, cfg_tab[i], seed));
         chk(16'(parity_error), 16'h0000);
         chk(16'(rxq.size()), 16'h0003);
         foreach (data[k]) chk(16'(rxq[k]), 16'(data[k]));
      end
      wr(6'h22, 8'h0f);
      fill(data);
      calc <= 1'b1;
      @(posedge sys_clk);
      calc <= 1'b0;
      @(negedge sys_clk);
      for (int t = 0; t < 200 && busy === 1'b1; t++) @(negedge sys_clk);
      must(!busy);
      chk(crc_value, crc_ref(data, 8'h0f, seed));
      end_sim();
   end
endmodule : tb_rf_channel_integrity_config
